// file: hdl/mirror_pkg.sv
/*
 * Shared constants for the mirror cell array and its display controller:
 * array geometry, reset grouping, link word layout, command codes and timing.
 * Assumes both ends run on a 100 MHz system clock.
 */
package mirror_pkg;

   // ==========================================================================
   // Array geometry
   // ==========================================================================
   localparam int unsigned COLS = 1920;
   localparam int unsigned ROWS = 1080;
   localparam int unsigned ROW_W = 11;
   localparam int unsigned COL_W = 11;
   localparam int unsigned GROUPS = 8;
   localparam int unsigned ROWS_PER_GROUP = ROWS / GROUPS;

   // ==========================================================================
   // Link words and commands
   // ==========================================================================
   localparam int unsigned WORD_W = 16;
   localparam int unsigned WORDS_PER_ROW = COLS / WORD_W;
   localparam int unsigned IDX_W = 7;
   localparam int unsigned HDR_OP_LSB = 14;
   localparam int unsigned HDR_ARG_W = 11;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_APPLY = 2'h2;
   localparam logic [1:0] OP_PARK = 2'h3;

   // ==========================================================================
   // Mirror position codes seen at the probe
   // ==========================================================================
   localparam logic [1:0] POS_PARKED = 2'h0;
   localparam logic [1:0] POS_OFF = 2'h1;
   localparam logic [1:0] POS_ON = 2'h2;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int unsigned SYS_PERIOD_NS = 10;
   localparam int unsigned LINK_HALF_NS = 40;
   localparam int unsigned LINK_HALF_CYC = LINK_HALF_NS / SYS_PERIOD_NS;
   localparam logic [1:0] EDGE_PH = 2'(LINK_HALF_CYC / 2 - 1);
   localparam logic [1:0] LOAD_PH = 2'(LINK_HALF_CYC - 1);
   localparam logic [4:0] GAP_CYC = 5'h10;

endpackage : mirror_pkg

// file: hdl/mirror_link_if.sv
/*
 * Link between the display controller and the mirror cell array.
 * The differential pairs are modelled as single-ended logic levels.
 */
`timescale 1ns/1ps

interface mirror_link_if;
   logic link_clk;
   logic link_frame;
   logic [15:0] link_data;
   logic link_busy;

   // ==========================================================================
   // Controller end
   // ==========================================================================
   modport ctrl (output link_clk, output link_frame, output link_data, input link_busy);

   // ==========================================================================
   // Array end
   // ==========================================================================
   modport dev (input link_clk, input link_frame, input link_data, output link_busy);
endinterface : mirror_link_if

// file: hdl/mirror_array_dev.sv
/*
 * Mirror cell array: storage cells written over the double-edge link, mirror
 * state applied per reset group, and a probe port that shows one cell.
 * Assumes the controller end drives the link and waits while busy is high.
 */
`timescale 1ns/1ps

module mirror_array_dev (
   input wire logic clk_sys_i, // System clock, 100 MHz.
   input wire logic rst_b_i, // Asynchronous reset, active low.
   mirror_link_if.dev link, // Link from the controller.
   input wire logic [10:0] probe_row_i, // Row of the probed cell.
   input wire logic [10:0] probe_col_i, // Column of the probed cell.
   output logic cell_true_o, // Stored value of the probed cell.
   output logic cell_inverse_out_o, // Inverse of the probed cell.
   output logic [1:0] mirror_pos_o, // Position of the probed mirror.
   output logic [7:0] mirror_group_reset_o, // One-cycle pulse per applied group.
   output logic landed_o // High while the array is landed.
);

   // ==========================================================================
   // Types and state
   // ==========================================================================
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_APPLY = 2'b10
   } dev_state_e;

   typedef struct packed {
      dev_state_e st;
      logic [1:0] clk_s;
      logic [1:0] frm_s;
      logic [1:0][15:0] dat_s;
      logic clk_prev;
      logic frm_prev;
      logic [6:0] idx;
      logic [15:0] hdr;
      logic [10:0] row;
      logic [7:0] mask;
      logic [7:0] grp_rst;
      logic landed;
      logic cell_q;
      logic [1:0] pos;
   } dev_s;

   dev_s r;
   dev_s nxt;

   // Storage cells and applied mirror state, one bit per mirror.
   logic [mirror_pkg::COLS-1:0] cell_mem [mirror_pkg::ROWS];
   logic [mirror_pkg::COLS-1:0] mirror_mem [mirror_pkg::ROWS];

   logic link_edge;
   logic frame_end;
   logic wr_en;
   logic [10:0] wr_row;
   logic [10:0] wr_base;
   logic copy_en;
   logic probe_ok;
   logic mirror_bit;

   // ==========================================================================
   // Group decoding
   // ==========================================================================
   // Gives the reset group that a row belongs to.
   function automatic logic [2:0] group_of(input logic [10:0] row);
      group_of = 3'(row / 11'(mirror_pkg::ROWS_PER_GROUP));
   endfunction : group_of

   // Tells whether a row is the last one of its group.
   function automatic logic group_last(input logic [10:0] row);
      group_last = (row % 11'(mirror_pkg::ROWS_PER_GROUP))
                   == 11'(mirror_pkg::ROWS_PER_GROUP - 1);
   endfunction : group_last

   // ==========================================================================
   // Next-state logic
   // ==========================================================================
   // The link clock is found by its edges after two flip-flops; the first
   // stage of every synchroniser feeds only the second.
   always_comb begin
      nxt = r;
      wr_en = 1'b0;
      copy_en = 1'b0;
      wr_row = r.hdr[10:0];
      wr_base = {r.idx - 7'h1, 4'h0};
      probe_ok = (probe_row_i < 11'(mirror_pkg::ROWS))
                 && (probe_col_i < 11'(mirror_pkg::COLS));
      mirror_bit = 1'b0;

      nxt.clk_s = {r.clk_s[0], link.link_clk};
      nxt.frm_s = {r.frm_s[0], link.link_frame};
      nxt.dat_s = {r.dat_s[0], link.link_data};
      nxt.clk_prev = r.clk_s[1];
      nxt.frm_prev = r.frm_s[1];
      nxt.grp_rst = 8'h00;

      // Any edge of the link clock inside a frame carries a word.
      link_edge = (r.clk_s[1] ^ r.clk_prev) && r.frm_s[1];
      frame_end = r.frm_prev && !r.frm_s[1];

      // Words are taken in order: header first, then row data.
      if (link_edge) begin
         if (r.idx == 7'h00) begin
            nxt.hdr = r.dat_s[1];
         end else if (r.hdr[15:14] == mirror_pkg::OP_WRITE
                      && r.idx <= 7'(mirror_pkg::WORDS_PER_ROW)
                      && r.hdr[10:0] < 11'(mirror_pkg::ROWS)) begin
            wr_en = 1'b1;
         end
         if (r.idx != 7'h7f) begin
            nxt.idx = r.idx + 7'h1;
         end
      end

      // Apply and park commands take effect when their frame closes.
      if (frame_end) begin
         nxt.idx = 7'h00;
         case (r.hdr[15:14])
            mirror_pkg::OP_APPLY: begin
               nxt.st = ST_APPLY;
               nxt.row = 11'h000;
               nxt.mask = r.hdr[7:0];
            end
            mirror_pkg::OP_PARK: begin
               nxt.landed = r.hdr[0];
            end
            default: begin
               nxt.mask = r.mask;
            end
         endcase
      end

      // The apply engine walks every row once, copying selected groups.
      case (r.st)
         ST_IDLE: begin
            // The row counter holds; a closing apply frame restarts it at zero above.
         end
         ST_APPLY: begin
            copy_en = r.mask[group_of(r.row)];
            if (group_last(r.row)) begin
               nxt.grp_rst[group_of(r.row)] = r.mask[group_of(r.row)];
            end
            if (r.row == 11'(mirror_pkg::ROWS - 1)) begin
               nxt.st = ST_IDLE;
            end else begin
               nxt.row = r.row + 11'h001;
            end
         end
         default: begin
            nxt.st = ST_IDLE;
         end
      endcase

      // The probe shows one cell and the position of its mirror.
      if (probe_ok) begin
         nxt.cell_q = cell_mem[probe_row_i][probe_col_i];
         mirror_bit = mirror_mem[probe_row_i][probe_col_i];
      end else begin
         nxt.cell_q = 1'b0;
      end
      if (!r.landed) begin
         nxt.pos = mirror_pkg::POS_PARKED;
      end else if (mirror_bit) begin
         nxt.pos = mirror_pkg::POS_ON;
      end else begin
         nxt.pos = mirror_pkg::POS_OFF;
      end
   end

   // ==========================================================================
   // State register
   // ==========================================================================
   // Registers the whole state; the array powers up landed.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '{st: ST_IDLE, landed: 1'b1, default: '0};
      end else begin
         r <= nxt;
      end
   end

   // ==========================================================================
   // Storage and mirror memories
   // ==========================================================================
   // Cells change only when written; applies never touch them.
   always_ff @(posedge clk_sys_i) begin
      if (wr_en) begin
         cell_mem[wr_row][wr_base +: 16] <= r.dat_s[1];
      end
   end

   // Mirror state is refreshed only by the apply engine.
   always_ff @(posedge clk_sys_i) begin
      if (copy_en) begin
         mirror_mem[r.row] <= cell_mem[r.row];
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   // The cell drives both its value and the complement.
   assign cell_true_o = r.cell_q;
   assign cell_inverse_out_o = ~r.cell_q;
   assign mirror_pos_o = r.pos;
   assign mirror_group_reset_o = r.grp_rst;
   assign landed_o = r.landed;
   assign link.link_busy = (r.st == ST_APPLY);

endmodule : mirror_array_dev

// file: hdl/mirror_ctrl_end.sv
/*
 * Display controller end of the link: turns user commands into framed
 * double-edge link transfers, generating the link clock by a divider.
 * Assumes a user that offers commands and row words by valid and ready.
 */
`timescale 1ns/1ps

module mirror_ctrl_end (
   input wire logic clk_sys_i, // System clock, 100 MHz.
   input wire logic rst_b_i, // Asynchronous reset, active low.
   mirror_link_if.ctrl link, // Link to the array.
   input wire logic cmd_valid_i, // Command offered.
   input wire logic [1:0] cmd_op_i, // Command code.
   input wire logic [10:0] cmd_arg_i, // Row, group mask or landed flag.
   output logic cmd_ready_o, // Command taken this cycle.
   input wire logic word_valid_i, // Row word offered.
   input wire logic [15:0] word_i, // Row word, lowest columns first.
   output logic word_ready_o // Row word taken this cycle.
);

   // ==========================================================================
   // Types and state
   // ==========================================================================
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_XFER = 3'b010,
      ST_GAP = 3'b100
   } ctrl_state_e;

   typedef struct packed {
      ctrl_state_e st;
      logic [1:0] ph;
      logic lclk;
      logic frame;
      logic [15:0] data;
      logic [6:0] left;
      logic [4:0] gap;
      logic [1:0] busy_s;
   } ctrl_s;

   ctrl_s r;
   ctrl_s nxt;

   // ==========================================================================
   // Next-state logic
   // ==========================================================================
   // Data changes mid-phase so it is steady around every clock edge.
   always_comb begin
      nxt = r;
      nxt.busy_s = {r.busy_s[0], link.link_busy};
      cmd_ready_o = (r.st == ST_IDLE) && !r.busy_s[1];
      word_ready_o = (r.st == ST_XFER) && (r.ph == mirror_pkg::LOAD_PH)
                     && (r.left != 7'h00);
      case (r.st)
         ST_IDLE: begin
            if (cmd_valid_i && cmd_ready_o) begin
               nxt.st = ST_XFER;
               nxt.frame = 1'b1;
               nxt.data = {cmd_op_i, 3'h0, cmd_arg_i};
               nxt.ph = 2'h0;
               nxt.left = (cmd_op_i == mirror_pkg::OP_WRITE)
                          ? 7'(mirror_pkg::WORDS_PER_ROW) : 7'h00;
            end
         end
         ST_XFER: begin
            if (r.ph == mirror_pkg::EDGE_PH) begin
               nxt.lclk = ~r.lclk;
               nxt.ph = r.ph + 2'h1;
            end else if (r.ph == mirror_pkg::LOAD_PH) begin
               if (r.left == 7'h00) begin
                  nxt.frame = 1'b0;
                  nxt.st = ST_GAP;
                  nxt.gap = mirror_pkg::GAP_CYC;
                  nxt.ph = 2'h0;
               end else if (word_valid_i) begin
                  nxt.data = word_i;
                  nxt.left = r.left - 7'h01;
                  nxt.ph = 2'h0;
               end
            end else begin
               nxt.ph = r.ph + 2'h1;
            end
         end
         ST_GAP: begin
            if (r.gap == 5'h00) begin
               nxt.st = ST_IDLE;
            end else begin
               nxt.gap = r.gap - 5'h01;
            end
         end
         default: begin
            nxt.st = ST_IDLE;
         end
      endcase
   end

   // ==========================================================================
   // State register
   // ==========================================================================
   // Registers the whole state of the controller end.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '{st: ST_IDLE, default: '0};
      end else begin
         r <= nxt;
      end
   end

   // Link outputs come straight from flip-flops.
   assign link.link_clk = r.lclk;
   assign link.link_frame = r.frame;
   assign link.link_data = r.data;

endmodule : mirror_ctrl_end

// file: sim/mirror_link_asserts.sv
/*
 * Concurrent checks on the link between the controller end and the cell array.
 * Assumes it is instantiated beside the link interface in the bench top.
 */
`timescale 1ns/1ps

module mirror_link_asserts (
   input wire logic clk_sys_i, // System clock.
   input wire logic rst_b_i, // Asynchronous reset, active low.
   input wire logic link_clk, // Link clock.
   input wire logic link_frame, // Frame level.
   input wire logic [15:0] link_data, // Link word.
   input wire logic link_busy // Apply engine running.
);
   // ==========================================================================
   // Helper logic
   // ==========================================================================
   int busy_cnt_r;

   // Counts the cycles of the current busy span, so its length can be judged.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_cnt_r <= 0;
      end else if (link_busy) begin
         busy_cnt_r <= busy_cnt_r + 1;
      end else begin
         busy_cnt_r <= 0;
      end
   end

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   // ==========================================================================
   // Sequences and checks
   // ==========================================================================
   sequence s_edge;
      $changed(link_clk);
   endsequence

   sequence s_clk_rest;
      $stable(link_clk) [*3];
   endsequence

   sequence s_gap;
      !link_frame [*8];
   endsequence

   edge_spacing_a: assert property (s_edge |=> s_clk_rest)
      else $error("link clock edges closer than four cycles");
   clk_idle_a: assert property (!link_frame && !$past(link_frame) |-> $stable(link_clk))
      else $error("link clock moved outside a frame");
   data_settled_a: assert property (link_frame && $changed(link_data) |-> $stable(link_clk))
      else $error("link word changed on a link clock edge");
   header_form_a: assert property ($rose(link_frame) |->
      link_data[13:11] == 3'h0 && link_data[15:14] != 2'h0)
      else $error("frame header malformed");
   first_edge_a: assert property ($rose(link_frame) |-> ##[1:8] s_edge)
      else $error("no link clock edge after frame start");
   frame_gap_a: assert property ($fell(link_frame) |-> s_gap)
      else $error("frames too close together");
   busy_excl_a: assert property (link_busy |-> !link_frame)
      else $error("frame sent while apply runs");
   busy_len_a: assert property ($fell(link_busy) |-> busy_cnt_r == int'(mirror_pkg::ROWS))
      else $error("apply span not one cycle per row");
endmodule : mirror_link_asserts

// file: sim/test_mirror_cell_array_apply.sv
/*
 * Self-checking bench joining the controller end and the cell array.
 * Assumes the design files under hdl/ are compiled first.
 */
`timescale 1ns/1ps

module test_mirror_cell_array_apply;
   // ==========================================================================
   // Signals and instances
   // ==========================================================================
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   logic [1:0] cmd_op_i = 2'h0;
   logic [10:0] cmd_arg_i = 11'h000;
   logic cmd_ready_o;
   logic word_valid_i = 1'b0;
   logic [15:0] word_i = 16'h0000;
   logic word_ready_o;
   logic [10:0] probe_row_i = 11'h000;
   logic [10:0] probe_col_i = 11'h000;
   logic cell_true_o;
   logic cell_inverse_out_o;
   logic [1:0] mirror_pos_o;
   logic [7:0] mirror_group_reset_o;
   logic landed_o;
   int err_total = 0;
   int comparisons = 0;
   logic [1919:0] exp_cell [int];
   logic [1919:0] exp_mir [int];
   int rows [5];
   logic [7:0] seen;

   mirror_link_if link_bus ();
   mirror_ctrl_end u_mirror_ctrl_end (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .link(link_bus), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
      .cmd_arg_i(cmd_arg_i), .cmd_ready_o(cmd_ready_o), .word_valid_i(word_valid_i),
      .word_i(word_i), .word_ready_o(word_ready_o));
   mirror_array_dev u_mirror_array_dev (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .link(link_bus), .probe_row_i(probe_row_i), .probe_col_i(probe_col_i),
      .cell_true_o(cell_true_o), .cell_inverse_out_o(cell_inverse_out_o),
      .mirror_pos_o(mirror_pos_o), .mirror_group_reset_o(mirror_group_reset_o),
      .landed_o(landed_o));
   mirror_link_asserts u_mirror_link_asserts (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .link_clk(link_bus.link_clk), .link_frame(link_bus.link_frame),
      .link_data(link_bus.link_data), .link_busy(link_bus.link_busy));

   // System clock at 100 MHz.
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // ==========================================================================
   // Tasks and functions
   // ==========================================================================
   function automatic logic [1:0] exp_pos(input logic landed, input logic v);
      if (!landed) return mirror_pkg::POS_PARKED;
      return v ? mirror_pkg::POS_ON : mirror_pkg::POS_OFF;
   endfunction : exp_pos

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic stop_test();
      if (err_total == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test

   // Offers one command and holds it until the edge that takes it.
   task automatic send_cmd(input logic [1:0] op, input logic [10:0] arg);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      cmd_valid_i <= 1'b1;
      cmd_op_i <= op;
      cmd_arg_i <= arg;
      do begin
         @(negedge clk_sys_i);
         n++;
      end while (cmd_ready_o !== 1'b1 && n < 3000);
      chk("command ready", 8'h01, 8'(cmd_ready_o));
      @(posedge clk_sys_i);
      cmd_valid_i <= 1'b0;
   endtask : send_cmd

   // Writes one row of random words, or the inverse of the row's last contents,
   // stalling now and then between words.
   task automatic write_row(input int row, input bit inv = 1'b0);
      logic [15:0] w;
      int n;
      send_cmd(mirror_pkg::OP_WRITE, 11'(row));
      for (int k = 0; k < int'(mirror_pkg::WORDS_PER_ROW); k++) begin
         w = inv ? ~exp_cell[row][16*k +: 16] : 16'($urandom);
         exp_cell[row][16*k +: 16] = w;
         word_valid_i <= 1'b1;
         word_i <= w;
         n = 0;
         do begin
            @(negedge clk_sys_i);
            n++;
         end while (word_ready_o !== 1'b1 && n < 100);
         chk("word ready", 8'h01, 8'(word_ready_o));
         @(posedge clk_sys_i);
         if ($urandom_range(3) == 0) begin
            word_valid_i <= 1'b0;
            @(posedge clk_sys_i);
         end
      end
      word_valid_i <= 1'b0;
   endtask : write_row

   // Requests an apply and gathers the group pulses until the engine stops.
   task automatic do_apply(input logic [7:0] mask);
      int n;
      seen = 8'h00;
      n = 0;
      send_cmd(mirror_pkg::OP_APPLY, {3'h0, mask});
      do begin
         @(negedge clk_sys_i);
         seen |= mirror_group_reset_o;
         n++;
      end while (!(link_bus.link_busy === 1'b0 && n > 20) && n < 3000);
      repeat (4) begin
         @(negedge clk_sys_i);
         seen |= mirror_group_reset_o;
      end
      chk("group pulses", mask, seen);
      foreach (rows[i]) begin
         if (mask[rows[i] / mirror_pkg::ROWS_PER_GROUP]) exp_mir[rows[i]] = exp_cell[rows[i]];
      end
   endtask : do_apply

   task automatic wait_landed(input logic v);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys_i);
         n++;
      end while (landed_o !== v && n < 50);
      chk("landed", 8'(v), 8'(landed_o));
   endtask : wait_landed

   // Probes the edge columns and one inner column of every tracked row.
   task automatic check_rows(input logic landed);
      int c;
      foreach (rows[i]) begin
         for (int j = 0; j < 3; j++) begin
            c = (j == 0) ? 0 : (j == 1) ? 1919 : $urandom_range(1918, 1);
            @(posedge clk_sys_i);
            probe_row_i <= 11'(rows[i]);
            probe_col_i <= 11'(c);
            repeat (2) @(negedge clk_sys_i);
            chk("cell", 8'(exp_cell[rows[i]][c]), 8'(cell_true_o));
            chk("inverse", 8'(!exp_cell[rows[i]][c]), 8'(cell_inverse_out_o));
            chk("position", 8'(exp_pos(landed, exp_mir[rows[i]][c])), 8'(mirror_pos_o));
         end
      end
   endtask : check_rows

   // ==========================================================================
   // Main sequence and watchdog
   // ==========================================================================
   initial begin
      void'($urandom(32'h3197));
      rows = '{0, 134, 135, 1079, 0};
      rows[4] = $urandom_range(1078, 136);
      repeat (12) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      send_cmd(mirror_pkg::OP_PARK, 11'h001);
      wait_landed(1'b1);
      foreach (rows[i]) write_row(rows[i]);
      do_apply(8'hff);
      check_rows(1'b1);
      foreach (rows[i]) write_row(rows[i]);
      check_rows(1'b1);
      do_apply(8'h81);
      check_rows(1'b1);
      send_cmd(mirror_pkg::OP_PARK, 11'h000);
      wait_landed(1'b0);
      check_rows(1'b0);
      send_cmd(mirror_pkg::OP_PARK, 11'h001);
      wait_landed(1'b1);
      check_rows(1'b1);
      foreach (rows[i]) write_row(rows[i], 1'b1);
      do_apply(8'hff);
      check_rows(1'b1);
      stop_test();
   end

   // Cuts a hang short well beyond the expected run of about 110 us.
   initial begin
      #500000;
      err_total++;
      stop_test();
   end
endmodule : test_mirror_cell_array_apply
